// File: rtl/pcid_regs.sv
/*
 * Configuration identity register bank: read-only identifiers, slot
 * clock bit and error reporting capability bits behind an APB slave.
 * Assumes one clock, synchronous reset and a well-behaved APB master.
 */
// What this block does
// [RULE1] Device_identifier: 16-bit read-only build value
// [RULE2] Vendor_identifier: 16-bit read-only build value
// [RULE3] All-ones vendor ids are refused as invalid
// [RULE4] Class code: 24-bit read-only build value
// [RULE5] Silicon_revision: 8-bit read-only build value
// [RULE6] Subsystem device_identifier: 16-bit read-only value
// [RULE7] Subsystem_vendor_identifier: 16-bit read-only value
// [RULE8] Common clock option sets slot clock bit
// [RULE9] Error reporting capability only when option chosen
// [RULE10] Option sets CRC check capable bit
// [RULE11] Option sets CRC generation capable bit
// [RULE12] CRC options need error reporting capability
// [RULE13] Writes change nothing; reads return build values
`timescale 1ns/1ns
`default_nettype none
module pcid_regs import pcid_pkg::*; #(
    parameter logic [15:0] DEV_ID = PCID_DEF_DEV_ID,
    parameter logic [15:0] VEN_ID = PCID_DEF_VEN_ID,
    parameter logic [23:0] CLASS_CODE = PCID_DEF_CLASS,
    parameter logic [7:0] REV_ID = PCID_DEF_REV,
    parameter logic [15:0] SUB_ID = PCID_DEF_SUB_ID,
    parameter logic [15:0] SUB_VEN = PCID_DEF_SUB_VEN,
    parameter bit COMMON_CLK = 1'b0,
    parameter bit AER_EN = 1'b1,
    parameter bit ECRC_CHK = 1'b0,
    parameter bit ECRC_GEN = 1'b0
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Build status
    output logic cfg_invalid
);

    // Build check outputs
    logic vid_bad;
    logic svid_bad;
    logic ecrc_bad;
    logic cfg_ok;

    // Read mux outputs
    logic [31:0] mux_rdata;
    logic mux_hit;

    // Bus answer state
    pcid_state_e state_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic cfg_invalid_r;

    // Words assembled from build values
    logic [31:0] id_word;
    logic [31:0] class_word;
    logic [31:0] subsys_word;
    logic [31:0] link_word;
    logic [31:0] aer_word;
    logic [31:0] stat_word;

    // Capability bits after the implemented gate
    logic aer_present;
    logic ecrc_chk_cap;
    logic ecrc_gen_cap;

    // Access phase seen in idle; answer due next edge
    logic setup_req;

    pcid_cfg_check #(
        .VEN_ID(VEN_ID),
        .SUB_VEN(SUB_VEN),
        .AER_EN(AER_EN),
        .ECRC_CHK(ECRC_CHK),
        .ECRC_GEN(ECRC_GEN)
    ) u_check (
        .vid_bad(vid_bad),
        .svid_bad(svid_bad),
        .ecrc_bad(ecrc_bad),
        .cfg_ok(cfg_ok)
    );

    // Identifier words, vendor in low half as config space lays them out
    assign id_word = {DEV_ID, VEN_ID};                // [RULE1] [RULE2]
    assign class_word = {CLASS_CODE, REV_ID};         // [RULE4] [RULE5]
    assign subsys_word = {SUB_ID, SUB_VEN};           // [RULE6] [RULE7]

    // Slot clock bit sits alone in the link status word
    always_comb begin
        link_word = PCID_ZERO_WORD;
        link_word[PCID_SLOT_CLK_BIT] = COMMON_CLK;    // [RULE8]
    end

    // Capability only exists when chosen; CRC bits cannot outlive it
    assign aer_present = AER_EN;                      // [RULE9]
    assign ecrc_chk_cap = ECRC_CHK && AER_EN;         // [RULE10] [RULE12]
    assign ecrc_gen_cap = ECRC_GEN && AER_EN;         // [RULE11] [RULE12]

    // Absent capability reads all zero
    always_comb begin
        aer_word = PCID_ZERO_WORD;
        aer_word[PCID_AER_PRES_BIT] = aer_present;
        aer_word[PCID_ECRC_CHK_BIT] = ecrc_chk_cap;
        aer_word[PCID_ECRC_GEN_BIT] = ecrc_gen_cap;
    end

    // Build check results visible to software
    always_comb begin
        stat_word = PCID_ZERO_WORD;
        stat_word[PCID_VID_BAD_BIT] = vid_bad;        // [RULE3]
        stat_word[PCID_SVID_BAD_BIT] = svid_bad;      // [RULE3]
        stat_word[PCID_ECRC_BAD_BIT] = ecrc_bad;      // [RULE12]
        stat_word[PCID_CFG_OK_BIT] = cfg_ok;
    end

    pcid_rd_mux u_mux (
        .addr(paddr[PCID_ADDR_W-1:0]),
        .id_word(id_word),
        .class_word(class_word),
        .subsys_word(subsys_word),
        .link_word(link_word),
        .aer_word(aer_word),
        .stat_word(stat_word),
        .rdata(mux_rdata),
        .hit(mux_hit)
    );

    // Access phase whose answer is not yet given
    assign setup_req = psel && penable && (state_r == PCID_IDLE);

    // Answer state: one wait state, then pready for one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= PCID_IDLE;
        end else if (clk_en) begin
            case (state_r)
                PCID_IDLE: begin
                    if (setup_req) begin
                        state_r <= PCID_DONE;
                    end
                end
                PCID_DONE: begin
                    state_r <= PCID_IDLE;
                end
                default: begin
                    state_r <= PCID_IDLE;
                end
            endcase
        end
    end

    // Ready pulse and error flag
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clk_en) begin
            pready_r <= setup_req;
            // Unmapped address or any write is an error; nothing stored
            pslverr_r <= setup_req && (!mux_hit || pwrite);  // [RULE13]
        end
    end

    // Read data: build values, zero on writes and unmapped words
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata_r <= PCID_ZERO_WORD;
        end else if (clk_en) begin
            if (setup_req && !pwrite) begin
                prdata_r <= mux_rdata;                // [RULE13]
            end else begin
                prdata_r <= PCID_ZERO_WORD;
            end
        end
    end

    // Invalid build flag, cleared by reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_invalid_r <= 1'b0;
        end else if (clk_en) begin
            cfg_invalid_r <= !cfg_ok;                 // [RULE3] [RULE12]
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cfg_invalid = cfg_invalid_r;

    // Write data and strobes are accepted but never stored
    logic unused_wr;
    assign unused_wr = ^{pwdata, pstrb, paddr[31:PCID_ADDR_W]};

    // Device_identifier read back exactly after a read of word zero
    a_dev_id_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_ID)
        |=> (prdata[31:PCID_HI_LSB] == DEV_ID) && pready)
        else $error("device_identifier read wrong");

    a_ven_id_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_ID)
        |=> prdata[PCID_ID_W-1:0] == VEN_ID)
        else $error("vendor_identifier read wrong");

    a_bad_vid_flag: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
        clk_en && (VEN_ID == PCID_ID_ALL_ONES || SUB_VEN == PCID_ID_ALL_ONES)
        |=> cfg_invalid)
        else $error("all ones id not refused");

    a_class_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE4]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_CLASS_REV)
        |=> prdata[31:PCID_CLASS_LSB] == CLASS_CODE)
        else $error("class code read wrong");

    a_rev_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_CLASS_REV)
        |=> prdata[PCID_REV_W-1:0] == REV_ID)
        else $error("revision read wrong");

    a_subsys_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_SUBSYS)
        |=> prdata[31:PCID_HI_LSB] == SUB_ID)
        else $error("subsystem_device_identifier read wrong");

    a_subven_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_SUBSYS)
        |=> prdata[PCID_ID_W-1:0] == SUB_VEN)
        else $error("subsystem vendor read wrong");

    a_slot_clk_bit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_LINK_STAT)
        |=> prdata[PCID_SLOT_CLK_BIT] == COMMON_CLK)
        else $error("slot clock bit wrong");

    a_aer_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_AER_CAP)
        |=> (prdata[PCID_AER_PRES_BIT] == AER_EN)
            && (AER_EN || prdata == PCID_ZERO_WORD))
        else $error("error capability gate wrong");

    a_ecrc_bits: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_AER_CAP)
        |=> prdata[PCID_ECRC_CHK_BIT] == (ECRC_CHK && AER_EN)
            && prdata[PCID_ECRC_GEN_BIT] == (ECRC_GEN && AER_EN))
        else $error("crc capable bits wrong");

    a_ecrc_needs: assert property (@(posedge clk) disable iff (sys_rst) // [RULE12]
        clk_en && (ECRC_CHK || ECRC_GEN) && !AER_EN |=> cfg_invalid)
        else $error("crc without error reporting not refused");

    a_write_refused: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        (clk_en && setup_req && pwrite)
        |=> pready && pslverr && prdata == PCID_ZERO_WORD)
        else $error("write not refused");

    a_ready_single: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        pready |=> !pready)
        else $error("ready held two cycles");

    // Every taken access is answered on the next edge
    a_ready_after_take: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        clk_en && setup_req |=> pready)
        else $error("taken access not answered");

    // No answer without a taken access
    a_no_stray_ready: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        clk_en && !setup_req |=> !pready)
        else $error("ready without access");

    // Unmapped words answer with an error and zero data
    a_unmapped_err: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        clk_en && setup_req && !mux_hit |=> pslverr && prdata == PCID_ZERO_WORD)
        else $error("unmapped access not refused");

    // Error flag only ever rides on the ready pulse
    a_err_with_ready: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        pslverr |-> pready)
        else $error("error without ready");

    // Data bus reads zero between answers
    a_rdata_idle: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        !pready |-> prdata == PCID_ZERO_WORD)
        else $error("read data not zero when idle");

    // Enable low freezes every answer register; guards the hold path
    a_enable_freeze: assert property (@(posedge clk) disable iff (sys_rst) // [RULE13]
        !clk_en && !sys_rst |=> $stable(pready) && $stable(pslverr) && $stable(prdata)
            && $stable(cfg_invalid))
        else $error("state moved while enable low");

    // Status word reports the vendor_identifier checks bit for bit
    a_stat_read: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
        (clk_en && setup_req && !pwrite && paddr[PCID_ADDR_W-1:0] == PCID_OFF_CFG_STAT)
        |=> prdata[PCID_VID_BAD_BIT] == (VEN_ID == PCID_ID_ALL_ONES)
            && prdata[PCID_SVID_BAD_BIT] == (SUB_VEN == PCID_ID_ALL_ONES))
        else $error("build status word wrong");

    // A legal build never raises the invalid flag
    a_cfg_ok_quiet: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
        clk_en && cfg_ok |=> !cfg_invalid)
        else $error("legal build flagged invalid");

    // Reset leaves the bus quiet; not disabled by reset on purpose
    a_reset_quiet: assert property (@(posedge clk) // [RULE13]
        sys_rst |=> !pready && !pslverr && prdata == PCID_ZERO_WORD && !cfg_invalid)
        else $error("outputs not cleared by reset");

endmodule : pcid_regs
`default_nettype wire

// File: rtl/pcid_pkg.sv
/*
 * Package for the configuration identity register bank: offsets, field
 * positions, widths and defaults shared by the bank and its helpers.
 * Assumes an APB slave with 32-bit data and word-aligned registers.
 */
package pcid_pkg;

    // Byte addresses of the identity registers
    localparam logic [7:0] PCID_OFF_ID = 8'h00;        // Device_identifier high, vendor_identifier low
    localparam logic [7:0] PCID_OFF_CLASS_REV = 8'h08; // Class code high, revision low
    localparam logic [7:0] PCID_OFF_SUBSYS = 8'h2c;    // Subsystem_device_identifier high, subsys vendor low
    localparam logic [7:0] PCID_OFF_LINK_STAT = 8'h40; // Link status word
    localparam logic [7:0] PCID_OFF_AER_CAP = 8'h44;   // Error reporting capability bits
    localparam logic [7:0] PCID_OFF_CFG_STAT = 8'h48;  // Build check status

    // Field widths
    localparam int PCID_ID_W = 16;
    localparam int PCID_CLASS_W = 24;
    localparam int PCID_REV_W = 8;
    localparam int PCID_ADDR_W = 8;

    // Field positions
    localparam int PCID_HI_LSB = 16;       // Upper half of an id word
    localparam int PCID_CLASS_LSB = 8;     // Class code above revision
    localparam int PCID_SLOT_CLK_BIT = 12; // Slot clock config in link status
    localparam int PCID_AER_PRES_BIT = 0;  // Error reporting capability present
    localparam int PCID_ECRC_GEN_BIT = 5;  // CRC generation capable
    localparam int PCID_ECRC_CHK_BIT = 7;  // CRC check capable
    localparam int PCID_VID_BAD_BIT = 0;   // Vendor_identifier is all ones
    localparam int PCID_SVID_BAD_BIT = 1;  // Subsystem_vendor_identifier all ones
    localparam int PCID_ECRC_BAD_BIT = 2;  // CRC option without error reporting
    localparam int PCID_CFG_OK_BIT = 3;    // Whole build choice valid

    // Forbidden identifier value
    localparam logic [15:0] PCID_ID_ALL_ONES = 16'hffff;

    // Neutral defaults; values arbitrary
    localparam logic [15:0] PCID_DEF_DEV_ID = 16'h0001;
    localparam logic [15:0] PCID_DEF_VEN_ID = 16'h1234;
    localparam logic [23:0] PCID_DEF_CLASS = 24'h000000;
    localparam logic [7:0] PCID_DEF_REV = 8'h01;
    localparam logic [15:0] PCID_DEF_SUB_ID = 16'h0001;
    localparam logic [15:0] PCID_DEF_SUB_VEN = 16'h1234;

    localparam logic [31:0] PCID_ZERO_WORD = 32'h00000000;

    // Bus answer state
    typedef enum logic [0:0] {
        PCID_IDLE = 1'b0,
        PCID_DONE = 1'b1
    } pcid_state_e;

endpackage : pcid_pkg

// File: rtl/pcid_cfg_check.sv
/*
 * Build-choice checker: flags identity and capability options that the
 * bank must refuse. Pure combinational; all inputs are parameters.
 */
`timescale 1ns/1ns
`default_nettype none
module pcid_cfg_check import pcid_pkg::*; #(
    parameter logic [15:0] VEN_ID = PCID_DEF_VEN_ID,
    parameter logic [15:0] SUB_VEN = PCID_DEF_SUB_VEN,
    parameter bit AER_EN = 1'b1,
    parameter bit ECRC_CHK = 1'b0,
    parameter bit ECRC_GEN = 1'b0
) (
    // Check results
    output wire logic vid_bad,
    output wire logic svid_bad,
    output wire logic ecrc_bad,
    output wire logic cfg_ok
);
    // All ones would read as an empty slot to config software
    assign vid_bad = (VEN_ID == PCID_ID_ALL_ONES);           // [RULE3]
    assign svid_bad = (SUB_VEN == PCID_ID_ALL_ONES);         // [RULE3]
    // CRC options need the error reporting capability
    assign ecrc_bad = (ECRC_CHK || ECRC_GEN) && !AER_EN;     // [RULE12]
    assign cfg_ok = !(vid_bad || svid_bad || ecrc_bad);
endmodule : pcid_cfg_check
`default_nettype wire

// File: rtl/pcid_rd_mux.sv
/*
 * Read multiplexer: maps an APB byte address to a read-only word.
 * Assumes all word inputs are stable build values or registered status.
 */
`timescale 1ns/1ns
`default_nettype none
module pcid_rd_mux import pcid_pkg::*; (
    // Address in
    input wire logic [PCID_ADDR_W-1:0] addr,
    // Word sources
    input wire logic [31:0] id_word,
    input wire logic [31:0] class_word,
    input wire logic [31:0] subsys_word,
    input wire logic [31:0] link_word,
    input wire logic [31:0] aer_word,
    input wire logic [31:0] stat_word,
    // Result
    output logic [31:0] rdata,
    output logic hit
);
    // Address decode with unmapped words reading zero
    always_comb begin
        hit = 1'b1;
        if (addr == PCID_OFF_ID) begin
            rdata = id_word;
        end else if (addr == PCID_OFF_CLASS_REV) begin
            rdata = class_word;
        end else if (addr == PCID_OFF_SUBSYS) begin
            rdata = subsys_word;
        end else if (addr == PCID_OFF_LINK_STAT) begin
            rdata = link_word;
        end else if (addr == PCID_OFF_AER_CAP) begin
            rdata = aer_word;
        end else if (addr == PCID_OFF_CFG_STAT) begin
            rdata = stat_word;
        end else begin
            rdata = PCID_ZERO_WORD;
            hit = 1'b0;
        end
    end
endmodule : pcid_rd_mux
`default_nettype wire

// File: bench/pcid_apb_host.sv
/*
 * APB host model standing in for configuration software.
 * Assumes one clock and a slave that answers through pready.
 */
`timescale 1ns/1ns
`default_nettype none
module pcid_apb_host (
    // Clock
    input wire logic clk,
    // Request side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // Answer side
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        pstrb = 4'hf;
    end

    // One transfer; request held until pready is seen high at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, output logic [31:0] rd,
        output logic er);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h000000, a};
        pwdata <= 32'ha5a5a5a5; // Pattern only; the bank must ignore it
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        // Bounded wait so a dead slave shows up as unknown data
        while (pready !== 1'b1 && n < 64) begin
            @(posedge clk);
            n++;
        end
        rd = (n < 64) ? prdata : 32'hxxxxxxxx;
        er = (n < 64) ? pslverr : 1'bx;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : pcid_apb_host
`default_nettype wire

// File: bench/test_pcid_regs.sv
/*
 * Testbench for the identity register bank: a legal build and an
 * illegal build side by side, both read over APB, only the legal one written.
 * Assumes the bank answers one cycle after the access phase starts.
 */
`timescale 1ns/1ns
`default_nettype none
module test_pcid_regs;
    import pcid_pkg::*;
    // Clock, reset and counters
    logic clk;
    logic sys_rst;
    logic clk_en;
    int err_total;
    int check_count;
    // Bus nets; index 0 legal build, 1 illegal build
    wire logic [1:0] psel, penable, pwrite, pready, pslverr, cfg_inv;
    wire logic [31:0] paddr[2], pwdata[2], prdata[2];
    wire logic [3:0] pstrb[2];
    // Build values, shared by the instances and the expectations
    localparam logic [15:0] A_DEV = 16'ha5c3;
    localparam logic [15:0] A_VEN = 16'h5a3c;
    localparam logic [23:0] A_CLASS = 24'h0c0330;
    localparam logic [7:0] A_REV = 8'h7e;
    localparam logic [15:0] A_SUB = 16'h1357;
    localparam logic [15:0] A_SVEN = 16'h2468;
    localparam bit A_CCLK = 1'b1;
    localparam bit A_AER = 1'b1;
    localparam bit A_CHK = 1'b1;
    localparam bit A_GEN = 1'b0;
    localparam logic [15:0] B_DEV = 16'h0001;
    localparam logic [15:0] B_VEN = 16'hffff;
    localparam logic [15:0] B_SVEN = 16'hffff;
    localparam bit B_CCLK = 1'b0;
    localparam bit B_AER = 1'b0;
    localparam bit B_CHK = 1'b1;
    localparam bit B_GEN = 1'b1;

    // Legal build: CRC check on, generation off, to tell the bits apart
    pcid_regs #(.DEV_ID(A_DEV), .VEN_ID(A_VEN), .CLASS_CODE(A_CLASS),
        .REV_ID(A_REV), .SUB_ID(A_SUB), .SUB_VEN(A_SVEN), .COMMON_CLK(A_CCLK),
        .AER_EN(A_AER), .ECRC_CHK(A_CHK), .ECRC_GEN(A_GEN)) u_pcid_regs (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel[0]),
        .penable(penable[0]), .pwrite(pwrite[0]), .paddr(paddr[0]), .pwdata(pwdata[0]),
        .pstrb(pstrb[0]), .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]),
        .cfg_invalid(cfg_inv[0]));
    // Illegal build: all-ones vendor ids, CRC options without error reporting
    pcid_regs #(.DEV_ID(B_DEV), .VEN_ID(B_VEN), .SUB_VEN(B_SVEN),
        .COMMON_CLK(B_CCLK), .AER_EN(B_AER), .ECRC_CHK(B_CHK), .ECRC_GEN(B_GEN)) u_pcid_regs_b (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel[1]),
        .penable(penable[1]), .pwrite(pwrite[1]), .paddr(paddr[1]), .pwdata(pwdata[1]),
        .pstrb(pstrb[1]), .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]),
        .cfg_invalid(cfg_inv[1]));
    // One host model per bank
    pcid_apb_host u_host (.clk(clk), .psel(psel[0]), .penable(penable[0]),
        .pwrite(pwrite[0]), .paddr(paddr[0]), .pwdata(pwdata[0]), .pstrb(pstrb[0]),
        .prdata(prdata[0]), .pready(pready[0]), .pslverr(pslverr[0]));
    pcid_apb_host u_host_b (.clk(clk), .psel(psel[1]), .penable(penable[1]),
        .pwrite(pwrite[1]), .paddr(paddr[1]), .pwdata(pwdata[1]), .pstrb(pstrb[1]),
        .prdata(prdata[1]), .pready(pready[1]), .pslverr(pslverr[1]));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One access on bank b, checking data and error answer
    task automatic acc(input bit b, input logic wr, input logic [7:0] a,
        input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic er;
        if (b) u_host_b.xfer(wr, a, rd, er);
        else u_host.xfer(wr, a, rd, er);
        chk("prdata", e, rd);
        chk("pslverr", {31'h0, ee}, {31'h0, er});
    endtask : acc

    // Verdict; also reached from the watchdog
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    // Watchdog; tests need well under a thousand cycles
    initial begin
        #40000;
        err_total++;
        final_report();
    end

    // Test sequence
    initial begin
        err_total = 0;
        check_count = 0;
        clk_en = 1'b1;
        sys_rst = 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        // Legal build values
        acc(0, 0, PCID_OFF_ID, {A_DEV, A_VEN}, 0);
        acc(0, 0, PCID_OFF_CLASS_REV, {A_CLASS, A_REV}, 0);
        acc(0, 0, PCID_OFF_SUBSYS, {A_SUB, A_SVEN}, 0);
        acc(0, 0, PCID_OFF_LINK_STAT, 32'h1 << PCID_SLOT_CLK_BIT, 0);
        acc(0, 0, PCID_OFF_AER_CAP, 32'h00000081, 0);
        acc(0, 0, PCID_OFF_CFG_STAT, 32'h1 << PCID_CFG_OK_BIT, 0);
        acc(0, 0, 8'h10, 32'h00000000, 1);
        chk("cfg_invalid", 32'h0, {31'h0, cfg_inv[0]});
        $display("test legal_reads done");
        // Writes are refused and leave values intact
        acc(0, 1, PCID_OFF_ID, 32'h00000000, 1);
        acc(0, 1, PCID_OFF_CLASS_REV, 32'h00000000, 1);
        acc(0, 1, PCID_OFF_SUBSYS, 32'h00000000, 1);
        acc(0, 0, PCID_OFF_ID, {A_DEV, A_VEN}, 0);
        acc(0, 0, PCID_OFF_CLASS_REV, {A_CLASS, A_REV}, 0);
        acc(0, 0, PCID_OFF_SUBSYS, {A_SUB, A_SVEN}, 0);
        $display("test writes done");
        // Enable low for four edges: the access waits, then completes
        fork
            acc(0, 0, PCID_OFF_ID, {A_DEV, A_VEN}, 0);
            begin
                @(posedge clk);
                clk_en <= 1'b0;
                repeat (4) @(posedge clk);
                chk("pready_frozen", 32'h0, {31'h0, pready[0]});
                clk_en <= 1'b1;
            end
        join
        $display("test clock_enable done");
        // Illegal build flagged; error caps absent
        acc(1, 0, PCID_OFF_ID, {B_DEV, B_VEN}, 0);
        acc(1, 0, PCID_OFF_LINK_STAT, 32'h00000000, 0);
        acc(1, 0, PCID_OFF_AER_CAP, 32'h00000000, 0);
        acc(1, 0, PCID_OFF_CFG_STAT, 32'h00000007, 0);
        chk("cfg_invalid", 32'h1, {31'h0, cfg_inv[1]});
        $display("test illegal_build done");
        // Reset in mid-run clears the flag, which returns afterwards
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        chk("cfg_invalid_rst", 32'h0, {31'h0, cfg_inv[1]});
        acc(1, 0, PCID_OFF_CFG_STAT, 32'h00000007, 0);
        chk("cfg_invalid_again", 32'h1, {31'h0, cfg_inv[1]});
        acc(0, 0, PCID_OFF_ID, {A_DEV, A_VEN}, 0);
        $display("test mid_reset done");
        final_report();
    end
endmodule : test_pcid_regs
`default_nettype wire
